// ### src/timer_channel_pkg.sv
// Overview of operation
// RL1 - without center alignment and mode-b clear, mode-a picks capture (0) or compare (1)
// RL2 - outside party keeps the pin stable two bus cycles before entering capture
// RL3 - edge/level field 00 releases the pin regardless of other mode bits
// RL4 - capture edges: 01 rising, 10 falling, 11 either edge
// RL5 - compare match: 01 toggles, 10 drives low, 11 drives high
// RL6 - mode-b set gives edge-aligned pwm, high-true for 10, low-true for x1
// RL7 - center alignment forces center-aligned pwm on up-count compare, 10 or x1
// RL8 - 16-bit value holds capture or compare value, zero after reset
// RL9 - capture-mode read of either byte latches both until other byte is read
// RL10 - any status/control write unlatches the capture read buffer, debug or not
// RL11 - value writes are discarded while in capture mode
// RL12 - in debug reads leave latch state frozen and return the live value
// RL13 - compare/pwm writes go to a buffer; clock off updates on second byte
// RL14 - compare mode with clock: transfer at next counter step after both bytes
// RL15 - pwm with clock: transfer when counter reaches modulo, or 0xffff free-running
// RL16 - status/control write resets the write-buffer byte sequence, debug or not
// RL17 - bytes may arrive high first or low first, applied as one 16-bit value
// RL18 - in debug value writes go straight to the register, buffer state frozen
// RL19 - debug writes leave a half-done buffered write intact for later completion
// RL20 - unit-wide bit selects center-aligned pwm for all channels when set
// RL21 - counter clock select 00 means stopped, and is the reset state
`default_nettype none
package timer_channel_pkg;
    localparam logic [4:0] CHANNEL_STATUS_CONTROL_OFS = 5'h00;
    localparam logic [4:0] CHANNEL_VALUE_HIGH_OFS = 5'h04;
    localparam logic [4:0] CHANNEL_VALUE_LOW_OFS = 5'h08;
    localparam logic [4:0] UNIT_CONTROL_OFS = 5'h0c;

    localparam int SC_IE_BIT = 6;
    localparam int SC_MODE_B_BIT = 5;
    localparam int SC_MODE_A_BIT = 4;
    localparam int SC_EDGE_LEVEL_B_BIT = 3;
    localparam int SC_EDGE_LEVEL_A_BIT = 2;

    localparam int UC_CLK_SEL_LO_BIT = 0;
    localparam int UC_CLK_SEL_HI_BIT = 1;
    localparam int UC_CENTER_ALIGN_BIT = 5;
    localparam int UC_WRITE_PENDING_BIT = 8;
    localparam int UC_READ_LATCHED_BIT = 9;
    localparam int UC_WRITE_HIGH_SEEN_BIT = 10;
    localparam int UC_WRITE_LOW_SEEN_BIT = 11;

    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
    localparam logic [15:0] CHANNEL_VALUE_RESET = 16'h0000;
    localparam logic [1:0] CLK_SEL_RESET = 2'h0;
    localparam logic [15:0] FREE_RUN_TERMINAL = 16'hffff;
    localparam logic [15:0] FREE_RUN_MODULO = 16'h0000;

    localparam logic [1:0] EDGE_LEVEL_RELEASE = 2'h0;
    localparam logic [1:0] CLK_SEL_STOPPED = 2'h0;

    typedef enum logic [2:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTER_PWM
    } chan_mode_t;
endpackage : timer_channel_pkg
`default_nettype wire

// ### src/timer_channel.sv
`timescale 1ns/1ps
`default_nettype none
module timer_channel #(
    parameter int VALUE_WIDTH = 16
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [4:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic [15:0] counter_in,
    input wire logic counter_step_in,
    input wire logic count_up_in,
    input wire logic [15:0] modulo_in,
    input wire logic background_debug_active_in,
    input wire logic chan_pin_in,
    output logic chan_pin_out,
    output logic chan_pin_oe_out,
    output logic capture_event_out,
    output logic compare_event_out
);

    if (VALUE_WIDTH != 16) begin : g_width_check
        $error("timer_channel supports only a 16-bit channel value");
    end

    // bus handshake: one wait cycle, request taken on the second edge
    logic ack;
    logic req;
    logic take;
    logic take_write;
    logic take_read;
    logic [4:0] reg_addr;

    assign req = (read_in || write_in) && !(read_in && write_in);
    assign waitrequest_out = req && !ack;
    assign take = req && ack;
    assign take_write = take && write_in && byteenable_in[0];
    assign take_read = take && read_in;
    assign reg_addr = {address_in[4:2], 2'b00};

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    // register fields
    logic chan_ie;
    logic chan_mode_b;
    logic chan_mode_a;
    logic edge_level_b;
    logic edge_level_a;
    logic center_align_select;
    logic counter_clk_sel_hi;
    logic counter_clk_sel_lo;
    logic [15:0] chan_value;

    logic wr_sc;
    logic wr_hi;
    logic wr_lo;
    logic wr_uc;
    logic rd_hi;
    logic rd_lo;

    assign wr_sc = take_write && reg_addr == timer_channel_pkg::CHANNEL_STATUS_CONTROL_OFS;
    assign wr_hi = take_write && reg_addr == timer_channel_pkg::CHANNEL_VALUE_HIGH_OFS;
    assign wr_lo = take_write && reg_addr == timer_channel_pkg::CHANNEL_VALUE_LOW_OFS;
    assign wr_uc = take_write && reg_addr == timer_channel_pkg::UNIT_CONTROL_OFS;
    assign rd_hi = take_read && reg_addr == timer_channel_pkg::CHANNEL_VALUE_HIGH_OFS;
    assign rd_lo = take_read && reg_addr == timer_channel_pkg::CHANNEL_VALUE_LOW_OFS;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chan_ie <= timer_channel_pkg::STATUS_CONTROL_RESET[timer_channel_pkg::SC_IE_BIT];
            chan_mode_b <= timer_channel_pkg::STATUS_CONTROL_RESET[timer_channel_pkg::SC_MODE_B_BIT];
            chan_mode_a <= timer_channel_pkg::STATUS_CONTROL_RESET[timer_channel_pkg::SC_MODE_A_BIT];
            edge_level_b <= timer_channel_pkg::STATUS_CONTROL_RESET[timer_channel_pkg::SC_EDGE_LEVEL_B_BIT];
            edge_level_a <= timer_channel_pkg::STATUS_CONTROL_RESET[timer_channel_pkg::SC_EDGE_LEVEL_A_BIT];
        end else if (wr_sc) begin
            chan_ie <= writedata_in[timer_channel_pkg::SC_IE_BIT];
            chan_mode_b <= writedata_in[timer_channel_pkg::SC_MODE_B_BIT];
            chan_mode_a <= writedata_in[timer_channel_pkg::SC_MODE_A_BIT];
            edge_level_b <= writedata_in[timer_channel_pkg::SC_EDGE_LEVEL_B_BIT];
            edge_level_a <= writedata_in[timer_channel_pkg::SC_EDGE_LEVEL_A_BIT];
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            center_align_select <= 1'b0;
            counter_clk_sel_hi <= timer_channel_pkg::CLK_SEL_RESET[1]; // RL21
            counter_clk_sel_lo <= timer_channel_pkg::CLK_SEL_RESET[0]; // RL21
        end else if (wr_uc) begin
            center_align_select <= writedata_in[timer_channel_pkg::UC_CENTER_ALIGN_BIT]; // RL20
            counter_clk_sel_hi <= writedata_in[timer_channel_pkg::UC_CLK_SEL_HI_BIT];
            counter_clk_sel_lo <= writedata_in[timer_channel_pkg::UC_CLK_SEL_LO_BIT];
        end
    end

    // mode decode
    timer_channel_pkg::chan_mode_t mode;
    logic [1:0] edge_level;
    logic pin_used;
    logic clk_stopped;

    assign edge_level = {edge_level_b, edge_level_a};
    assign pin_used = edge_level != timer_channel_pkg::EDGE_LEVEL_RELEASE; // RL3
    assign clk_stopped = {counter_clk_sel_hi, counter_clk_sel_lo} == timer_channel_pkg::CLK_SEL_STOPPED; // RL21

    always_comb begin
        if (center_align_select) begin
            mode = timer_channel_pkg::MODE_CENTER_PWM; // RL7 RL20
        end else if (chan_mode_b) begin
            mode = timer_channel_pkg::MODE_EDGE_PWM; // RL6
        end else if (chan_mode_a) begin
            mode = timer_channel_pkg::MODE_COMPARE; // RL1
        end else begin
            mode = timer_channel_pkg::MODE_CAPTURE; // RL1
        end
    end

    logic in_capture;
    logic in_pwm;
    assign in_capture = mode == timer_channel_pkg::MODE_CAPTURE;
    assign in_pwm = mode == timer_channel_pkg::MODE_EDGE_PWM || mode == timer_channel_pkg::MODE_CENTER_PWM;

    // pin synchroniser and edge detect
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic cap_hit;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= chan_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // a pin that moved just before entering capture shows as an edge here
    assign cap_hit = in_capture && ((edge_level_a && pin_sync && !pin_prev)
        || (edge_level_b && !pin_sync && pin_prev)); // RL4 RL2

    // compare match sees the count that the counter has just taken
    logic match;
    assign match = counter_step_in && counter_in == chan_value && !in_capture;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            capture_event_out <= 1'b0;
            compare_event_out <= 1'b0;
        end else begin
            capture_event_out <= cap_hit;
            compare_event_out <= match;
        end
    end

    // capture read buffer
    logic rd_latched;
    logic rd_first_high;
    logic [15:0] rd_buf;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_latched <= 1'b0;
            rd_first_high <= 1'b0;
            rd_buf <= timer_channel_pkg::CHANNEL_VALUE_RESET;
        end else if (wr_sc) begin
            rd_latched <= 1'b0; // RL10
        end else if (in_capture && !background_debug_active_in && (rd_hi || rd_lo)) begin // RL12
            if (!rd_latched) begin
                rd_latched <= 1'b1; // RL9
                rd_first_high <= rd_hi;
                rd_buf <= chan_value;
            end else if (rd_first_high ? rd_lo : rd_hi) begin
                rd_latched <= 1'b0; // RL9
            end
        end
    end

    // compare write buffer
    logic wr_high_seen;
    logic wr_low_seen;
    logic wr_pending;
    logic [15:0] wr_buf;
    logic buf_wr_hi;
    logic buf_wr_lo;
    logic both_done;
    logic [15:0] next_buf;
    logic [15:0] pwm_terminal;
    logic transfer;

    assign buf_wr_hi = wr_hi && !in_capture && !background_debug_active_in; // RL11 RL18
    assign buf_wr_lo = wr_lo && !in_capture && !background_debug_active_in; // RL11 RL18
    assign both_done = (wr_high_seen || buf_wr_hi) && (wr_low_seen || buf_wr_lo) && (buf_wr_hi || buf_wr_lo); // RL17
    assign next_buf = {buf_wr_hi ? writedata_in[7:0] : wr_buf[15:8],
        buf_wr_lo ? writedata_in[7:0] : wr_buf[7:0]};
    assign pwm_terminal = modulo_in == timer_channel_pkg::FREE_RUN_MODULO
        ? timer_channel_pkg::FREE_RUN_TERMINAL : modulo_in;

    always_comb begin
        transfer = 1'b0;
        if (wr_pending && !clk_stopped && !background_debug_active_in) begin
            case (mode)
                timer_channel_pkg::MODE_COMPARE: transfer = counter_step_in; // RL14
                timer_channel_pkg::MODE_EDGE_PWM,
                timer_channel_pkg::MODE_CENTER_PWM: transfer = counter_step_in && counter_in == pwm_terminal; // RL15
                default: transfer = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_high_seen <= 1'b0;
            wr_low_seen <= 1'b0;
            wr_pending <= 1'b0;
            wr_buf <= timer_channel_pkg::CHANNEL_VALUE_RESET;
        end else if (wr_sc) begin
            wr_high_seen <= 1'b0; // RL16
            wr_low_seen <= 1'b0; // RL16
            wr_pending <= 1'b0; // RL16
        end else if (buf_wr_hi || buf_wr_lo) begin
            wr_buf <= next_buf; // RL13
            if (both_done) begin
                wr_high_seen <= 1'b0;
                wr_low_seen <= 1'b0;
                wr_pending <= !clk_stopped; // RL13 RL14 RL15
            end else begin
                wr_high_seen <= wr_high_seen || buf_wr_hi;
                wr_low_seen <= wr_low_seen || buf_wr_lo;
                // a same-cycle transfer took the old pair, so the half write must not ride on it
                wr_pending <= wr_pending && !transfer;
            end
        end else if (transfer) begin
            wr_pending <= 1'b0;
        end
    end

    // channel value: capture, buffered transfer or direct debug write
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chan_value <= timer_channel_pkg::CHANNEL_VALUE_RESET; // RL8
        end else if (cap_hit) begin
            chan_value <= counter_in; // RL8
        end else if (background_debug_active_in && !in_capture && (wr_hi || wr_lo)) begin
            // direct path leaves the buffer alone so a split write finishes later
            if (wr_hi) begin
                chan_value[15:8] <= writedata_in[7:0]; // RL18 RL19
            end else begin
                chan_value[7:0] <= writedata_in[7:0]; // RL18 RL19
            end
        end else if (both_done && clk_stopped) begin
            chan_value <= next_buf; // RL13 RL17
        end else if (transfer) begin
            chan_value <= wr_buf; // RL14 RL15 RL19
        end
    end

    // pin output level
    logic pin_level;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_level <= 1'b0;
        end else if (match) begin
            case (mode)
                timer_channel_pkg::MODE_COMPARE: begin
                    case (edge_level)
                        2'h1: pin_level <= !pin_level; // RL5
                        2'h2: pin_level <= 1'b0; // RL5
                        2'h3: pin_level <= 1'b1; // RL5
                        default: pin_level <= pin_level;
                    endcase
                end
                timer_channel_pkg::MODE_EDGE_PWM: pin_level <= edge_level_a; // RL6
                timer_channel_pkg::MODE_CENTER_PWM: pin_level <= count_up_in ? edge_level_a : !edge_level_a; // RL7
                default: pin_level <= pin_level;
            endcase
        end else if (mode == timer_channel_pkg::MODE_EDGE_PWM && counter_step_in
            && counter_in == timer_channel_pkg::FREE_RUN_MODULO) begin
            pin_level <= !edge_level_a; // RL6
        end
    end

    assign chan_pin_out = pin_level;
    assign chan_pin_oe_out = pin_used && !in_capture; // RL3

    // read data, registered on the wait cycle
    logic [31:0] next_readdata;

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (reg_addr)
            timer_channel_pkg::CHANNEL_STATUS_CONTROL_OFS: begin
                next_readdata[timer_channel_pkg::SC_IE_BIT] = chan_ie;
                next_readdata[timer_channel_pkg::SC_MODE_B_BIT] = chan_mode_b;
                next_readdata[timer_channel_pkg::SC_MODE_A_BIT] = chan_mode_a;
                next_readdata[timer_channel_pkg::SC_EDGE_LEVEL_B_BIT] = edge_level_b;
                next_readdata[timer_channel_pkg::SC_EDGE_LEVEL_A_BIT] = edge_level_a;
            end
            timer_channel_pkg::CHANNEL_VALUE_HIGH_OFS:
                next_readdata[7:0] = (rd_latched && in_capture && !background_debug_active_in)
                    ? rd_buf[15:8] : chan_value[15:8]; // RL9 RL12
            timer_channel_pkg::CHANNEL_VALUE_LOW_OFS:
                next_readdata[7:0] = (rd_latched && in_capture && !background_debug_active_in)
                    ? rd_buf[7:0] : chan_value[7:0]; // RL9 RL12
            timer_channel_pkg::UNIT_CONTROL_OFS: begin
                next_readdata[timer_channel_pkg::UC_CLK_SEL_LO_BIT] = counter_clk_sel_lo;
                next_readdata[timer_channel_pkg::UC_CLK_SEL_HI_BIT] = counter_clk_sel_hi;
                next_readdata[timer_channel_pkg::UC_CENTER_ALIGN_BIT] = center_align_select;
                next_readdata[timer_channel_pkg::UC_WRITE_PENDING_BIT] = wr_pending;
                next_readdata[timer_channel_pkg::UC_READ_LATCHED_BIT] = rd_latched;
                next_readdata[timer_channel_pkg::UC_WRITE_HIGH_SEEN_BIT] = wr_high_seen;
                next_readdata[timer_channel_pkg::UC_WRITE_LOW_SEEN_BIT] = wr_low_seen;
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            readdata_out <= 32'h0000_0000;
        end else if (read_in && !ack) begin
            readdata_out <= next_readdata;
        end
    end

endmodule : timer_channel
`default_nettype wire

// ### verif/timer_channel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timer_channel_asserts (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [4:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    input wire logic waitrequest_out,
    input wire logic count_up_in,
    input wire logic chan_pin_in,
    input wire logic chan_pin_out,
    input wire logic chan_pin_oe_out,
    input wire logic capture_event_out,
    input wire logic compare_event_out
);
    logic [7:0] sc;
    logic ca;
    logic take;
    logic cap_mode;
    logic [1:0] fld;
    // shadow of the mode bits, updated at the same taking edge as the design
    assign take = write_in && !waitrequest_out && byteenable_in[0];
    assign fld = sc[3:2];
    assign cap_mode = !ca && sc[5:4] == 2'h0;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sc <= 8'h00;
            ca <= 1'b0;
        end else if (take && address_in[4:2] == 3'h0) begin
            sc <= writedata_in[7:0];
        end else if (take && address_in[4:2] == 3'h3) begin
            ca <= writedata_in[5];
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    a_pin_release: assert property (fld == 2'h0 |-> !chan_pin_oe_out)
        else $error("pin driven with edge/level field clear");
    a_capture_input: assert property (cap_mode |-> !chan_pin_oe_out)
        else $error("pin driven in capture mode");
    a_output_drive: assert property (!cap_mode && fld != 2'h0 |-> chan_pin_oe_out)
        else $error("pin not driven in output mode");
    a_rise_only: assert property (capture_event_out && fld == 2'h1 |-> chan_pin_in && cap_mode)
        else $error("capture without rising edge");
    a_fall_only: assert property (capture_event_out && fld == 2'h2 |-> !chan_pin_in && cap_mode)
        else $error("capture without falling edge");
    a_compare_toggle: assert property (compare_event_out && !ca && sc[5:4] == 2'h1 && fld == 2'h1
        |-> chan_pin_out != $past(chan_pin_out))
        else $error("compare match did not toggle pin");
    a_compare_level: assert property (compare_event_out && !ca && sc[5:4] == 2'h1 && fld[1]
        |-> chan_pin_out == fld[0])
        else $error("compare match drove wrong level");
    a_edge_pwm: assert property (compare_event_out && !ca && sc[5] && fld != 2'h0
        |-> chan_pin_out == fld[0])
        else $error("edge pwm wrong level on match");
    a_center_up: assert property (compare_event_out && ca && $past(count_up_in) && fld != 2'h0
        |-> chan_pin_out == fld[0])
        else $error("center pwm wrong level on up match");
    a_one_wait: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("waitrequest held past one cycle");
    c_capture: cover property (capture_event_out);
    c_center_match: cover property (compare_event_out && ca);
    c_write_taken: cover property (take);
endmodule : timer_channel_asserts
bind timer_channel timer_channel_asserts i_timer_channel_asserts (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .waitrequest_out(waitrequest_out), .count_up_in(count_up_in), .chan_pin_in(chan_pin_in),
    .chan_pin_out(chan_pin_out), .chan_pin_oe_out(chan_pin_oe_out),
    .capture_event_out(capture_event_out), .compare_event_out(compare_event_out));
`default_nettype wire

// ### verif/chan_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module chan_pin_model (
    input wire logic core_clk_in,
    input wire logic level_in,
    input wire logic pin_drive_in,
    input wire logic pin_oe_in,
    output logic wire_level_out
);
    logic held;
    // level only moves just after an edge and then rests for many cycles
    always_ff @(posedge core_clk_in) held <= level_in;
    // device drive wins while enabled, else the outside source is seen
    assign wire_level_out = pin_oe_in ? pin_drive_in : held;
endmodule : chan_pin_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %h seen %h", name, exp, got); end end
module tb;
    localparam logic [4:0] SC = timer_channel_pkg::CHANNEL_STATUS_CONTROL_OFS;
    localparam logic [4:0] VH = timer_channel_pkg::CHANNEL_VALUE_HIGH_OFS;
    localparam logic [4:0] VL = timer_channel_pkg::CHANNEL_VALUE_LOW_OFS;
    localparam logic [4:0] UC = timer_channel_pkg::UNIT_CONTROL_OFS;
    logic core_clk_in, arst_n_in, read_in, write_in, waitrequest_out, counter_step_in, count_up_in;
    logic [4:0] address_in;
    logic [31:0] writedata_in, readdata_out;
    logic [3:0] byteenable_in;
    logic [15:0] counter_in, modulo_in;
    logic background_debug_active_in, chan_pin_in, chan_pin_out, chan_pin_oe_out, pin_level;
    logic capture_event_out, compare_event_out;
    int failures = 0;
    int num_checks = 0;
    int cap_cnt = 0;
    int cmp_cnt = 0;
    logic [7:0] t_uc [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20};
    logic [7:0] t_sc [8] = '{8'h18, 8'h1c, 8'h14, 8'h14, 8'h28, 8'h24, 8'h08, 8'h04};
    logic t_pin [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    timer_channel i_timer_channel (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .counter_in(counter_in),
        .counter_step_in(counter_step_in), .count_up_in(count_up_in), .modulo_in(modulo_in),
        .background_debug_active_in(background_debug_active_in), .chan_pin_in(chan_pin_in),
        .chan_pin_out(chan_pin_out), .chan_pin_oe_out(chan_pin_oe_out),
        .capture_event_out(capture_event_out), .compare_event_out(compare_event_out));
    chan_pin_model i_chan_pin_model (.core_clk_in(core_clk_in), .level_in(pin_level),
        .pin_drive_in(chan_pin_out), .pin_oe_in(chan_pin_oe_out), .wire_level_out(chan_pin_in));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) if (capture_event_out === 1'b1) cap_cnt++;
    always @(posedge core_clk_in) if (compare_event_out === 1'b1) cmp_cnt++;
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // request held to the edge that sees waitrequest low; readdata taken at that edge, only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        address_in <= a;
        read_in <= !wr;
        write_in <= wr;
        writedata_in <= {24'h000000, d};
        @(posedge core_clk_in);
        while (waitrequest_out !== 1'b0) @(posedge core_clk_in);
        q = readdata_out[7:0];
        read_in <= 1'b0;
        write_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK("readdata", e, q)
    endtask : rd
    task automatic step(input logic [15:0] c);
        counter_in <= c;
        counter_step_in <= 1'b1;
        @(posedge core_clk_in);
        counter_step_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
    endtask : step
    task automatic pin(input logic v);
        pin_level <= v;
        repeat (8) @(posedge core_clk_in);
    endtask : pin
    initial begin
        arst_n_in = 1'b0;
        {read_in, write_in, counter_step_in, background_debug_active_in, pin_level} = 5'h00;
        address_in = 5'h00;
        writedata_in = 32'h00000000;
        byteenable_in = 4'hf;
        count_up_in = 1'b1;
        counter_in = 16'h0000;
        modulo_in = 16'h0100;
        repeat (6) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        @(posedge core_clk_in);
        rd(VH, 8'h00);
        rd(UC, 8'h00);
        rd(5'h10, 8'h00);
        wr(SC, 8'h14);
        wr(VL, 8'h34);
        rd(VL, 8'h00);
        wr(VH, 8'h12);
        rd(VH, 8'h12);
        rd(VL, 8'h34);
        wr(VH, 8'h55);
        wr(SC, 8'h14);
        wr(VL, 8'h66);
        rd(VL, 8'h34);
        wr(VH, 8'h55);
        rd(VL, 8'h66);
        for (int i = 0; i < 8; i++) begin
            wr(UC, t_uc[i]);
            wr(SC, t_sc[i]);
            step(16'h5566);
            `CHK("pin_oe", 1'b1, chan_pin_oe_out)
            `CHK("pin_level", t_pin[i], chan_pin_out)
        end
        count_up_in <= 1'b0;
        step(16'h5566);
        `CHK("pin_level", 1'b0, chan_pin_out)
        count_up_in <= 1'b1;
        `CHK("compares", 9, cmp_cnt)
        wr(UC, 8'h00);
        wr(SC, 8'h10);
        `CHK("pin_oe", 1'b0, chan_pin_oe_out)
        wr(UC, 8'h01);
        wr(SC, 8'h14);
        wr(VH, 8'h0a);
        wr(VL, 8'h0b);
        rd(VH, 8'h55);
        step(16'h0000);
        rd(VH, 8'h0a);
        wr(SC, 8'h28);
        wr(VH, 8'h0c);
        wr(VL, 8'h0d);
        step(16'h00ff);
        rd(VL, 8'h0b);
        step(16'h0100);
        rd(VL, 8'h0d);
        modulo_in <= 16'h0000;
        wr(VH, 8'h0f);
        wr(VL, 8'h0e);
        step(16'h0100);
        rd(VL, 8'h0d);
        step(16'hffff);
        rd(VL, 8'h0e);
        wr(UC, 8'h00);
        wr(SC, 8'h14);
        wr(VH, 8'h11);
        background_debug_active_in <= 1'b1;
        wr(VL, 8'h99);
        rd(VL, 8'h99);
        background_debug_active_in <= 1'b0;
        wr(VL, 8'h77);
        rd(VH, 8'h11);
        rd(VL, 8'h77);
        wr(SC, 8'h04);
        counter_in <= 16'h1234;
        pin(1'b1);
        `CHK("captures", 1, cap_cnt)
        rd(VH, 8'h12);
        counter_in <= 16'h5678;
        pin(1'b0);
        pin(1'b1);
        rd(VL, 8'h34);
        rd(VH, 8'h56);
        rd(VL, 8'h78);
        `CHK("captures", 2, cap_cnt)
        wr(VH, 8'hff);
        rd(VH, 8'h56);
        wr(SC, 8'h0c);
        counter_in <= 16'h9abc;
        pin(1'b0);
        rd(VL, 8'hbc);
        `CHK("captures", 3, cap_cnt)
        background_debug_active_in <= 1'b1;
        counter_in <= 16'hdef0;
        pin(1'b1);
        rd(VL, 8'hf0);
        rd(VH, 8'hde);
        background_debug_active_in <= 1'b0;
        rd(VH, 8'h9a);
        rd(VL, 8'hf0);
        `CHK("captures", 4, cap_cnt)
        final_report();
    end
    // whole sequence needs roughly three hundred cycles
    initial begin
        repeat (5000) @(posedge core_clk_in);
        failures++;
        final_report();
    end
endmodule : tb
`default_nettype wire
